// ===== logic/ccm_clock_select.sv
// Design decisions made here: the register addresses and the strobed register port.
`default_nettype none
module ccm_clock_select #(
	parameter logic [3:0] PLL_DIV = ccm_pkg::PLL_DIV_RST,
	parameter int unsigned CNT_W  = 8
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      swReset,
	input  wire logic                      xtalIn,
	input  wire logic [2:0]                strapPins,
	input  wire logic [ccm_pkg::ADDR_W-1:0] addr,
	input  wire logic [ccm_pkg::DATA_W-1:0] wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output logic      [ccm_pkg::DATA_W-1:0] rdata,
	output logic                           cpuClk,
	output logic                           cpuRise,
	output logic                           cpuFall,
	output logic                           pllOn,
	output logic                           oscBypass,
	output logic      [4:0]                mulFactor,
	output logic                           clkFail,
	output logic                           irq
);
	typedef struct packed {
		logic                     caught;
		logic [2:0]               strap;
		logic [4:0]               factor;
		logic                     bypass;
		logic                     monDis;
		logic                     fail;
		logic                     stat;
		logic                     mask;
		logic                     xtalPrev;
		logic [CNT_W-1:0]         halfLen;
		logic [CNT_W-1:0]         halfCnt;
		logic [CNT_W:0]           acc;
		logic [3:0]               pllDiv;
		logic [4:0]               monCnt;
		logic                     cpuClk;
		logic                     cpuRise;
		logic                     cpuFall;
		logic                     pllOn;
		logic                     irq;
		logic [ccm_pkg::DATA_W-1:0] rdata;
	} ccm_state_t;

	ccm_state_t s_q;
	ccm_state_t s_d;
	logic       xtalEdge;
	logic       xtalRise;
	logic       pllTick;
	logic       bypassMode;
	logic       monOn;
	logic       failEvt;
	logic       nextClk;
	logic [CNT_W:0] accSum;

	always_comb begin
		s_d = s_q;
		s_d.cpuRise = 1'b0;
		s_d.cpuFall = 1'b0;
		xtalEdge = xtalIn ^ s_q.xtalPrev;
		xtalRise = xtalIn & ~s_q.xtalPrev;
		s_d.xtalPrev = xtalIn;
		bypassMode = (s_q.strap == ccm_pkg::STRAP_DIRECT) || (s_q.strap == ccm_pkg::STRAP_PRESC);
		monOn = s_q.caught && bypassMode && !s_q.monDis && !s_q.fail;
		failEvt = 1'b0;
		nextClk = s_q.cpuClk;
		accSum = s_q.acc + {{(CNT_W-4){1'b0}}, s_q.factor};
		// strap capture right after release
		if (!s_q.caught) begin
			s_d.caught = 1'b1;
			s_d.strap = strapPins;
			s_d.factor = ccm_pkg::mul_factor(strapPins);
			s_d.bypass = (strapPins == ccm_pkg::STRAP_DIRECT);
		end
		// free-running pll tick divider
		pllTick = 1'b0;
		if (s_q.pllOn) begin
			if (s_q.pllDiv == PLL_DIV - 4'h1) begin
				pllTick = 1'b1;
				s_d.pllDiv = 4'h0;
			end else begin
				s_d.pllDiv = s_q.pllDiv + 4'h1;
			end
		end else begin
			s_d.pllDiv = 4'h0;
		end
		// loss monitor
		if (!monOn || xtalEdge) begin
			s_d.monCnt = 5'h00;
		end else if (pllTick) begin
			if (s_q.monCnt == ccm_pkg::MON_LAST) begin
				failEvt = 1'b1;
				s_d.monCnt = 5'h00;
			end else begin
				s_d.monCnt = s_q.monCnt + 5'h01;
			end
		end
		if (failEvt) begin
			s_d.fail = 1'b1;
		end
		// input half-period measurement for the multiplier
		if (xtalEdge) begin
			s_d.halfCnt = '0;
			s_d.halfLen = (s_q.halfCnt == {CNT_W{1'b1}}) ? s_q.halfCnt : s_q.halfCnt + 1'b1;
		end else if (s_q.halfCnt != {CNT_W{1'b1}}) begin
			s_d.halfCnt = s_q.halfCnt + 1'b1;
		end
		// cpu clock generation
		if (!s_q.caught) begin
			nextClk = 1'b0;
		end else if (s_q.fail) begin
			// phase before the switch already lasted at least sixteen ticks
			if (pllTick) begin
				nextClk = ~s_q.cpuClk;
			end
		end else begin
			case (s_q.strap)
				ccm_pkg::STRAP_DIRECT: nextClk = xtalIn;
				ccm_pkg::STRAP_PRESC: begin
					if (xtalRise) begin
						nextClk = ~s_q.cpuClk;
					end
				end
				default: begin
					// resync on each input rising edge, factor toggles per input half
					if (xtalRise) begin
						nextClk = 1'b1;
						s_d.acc = '0;
					end else if (accSum >= {1'b0, s_q.halfLen}) begin
						nextClk = ~s_q.cpuClk;
						s_d.acc = accSum - {1'b0, s_q.halfLen};
					end else begin
						s_d.acc = accSum;
					end
				end
			endcase
		end
		s_d.cpuClk = nextClk;
		s_d.cpuRise = nextClk & ~s_q.cpuClk;
		s_d.cpuFall = ~nextClk & s_q.cpuClk;
		// register port
		if (wr && addr == ccm_pkg::SYS_CFG_ADDR) begin
			s_d.monDis = wdata[ccm_pkg::MON_DIS_BIT];
		end
		if (wr && addr == ccm_pkg::MASK_ADDR) begin
			s_d.mask = wdata[0];
		end
		if (wr && addr == ccm_pkg::STATUS_ADDR && wdata[ccm_pkg::LOSS_EVT_BIT]) begin
			s_d.stat = 1'b0;
		end
		if (failEvt) begin
			s_d.stat = 1'b1;
		end
		s_d.rdata = '0;
		if (rd) begin
			case (addr)
				ccm_pkg::SYS_CFG_ADDR: s_d.rdata[ccm_pkg::MON_DIS_BIT] = s_q.monDis;
				ccm_pkg::STATUS_ADDR: s_d.rdata[ccm_pkg::LOSS_EVT_BIT] = s_q.stat;
				ccm_pkg::MASK_ADDR: s_d.rdata[0] = s_q.mask;
				ccm_pkg::MODE_ADDR: begin
					s_d.rdata[2:0] = s_q.strap;
					s_d.rdata[ccm_pkg::MODE_RDY_BIT] = s_q.caught;
					s_d.rdata[ccm_pkg::MODE_PLL_BIT] = s_q.pllOn;
					s_d.rdata[ccm_pkg::MODE_FAIL_BIT] = s_q.fail;
				end
				default: s_d.rdata = '0;
			endcase
		end
		// software or watchdog reset clears the failure and recaptures the straps
		if (swReset) begin
			s_d.caught = 1'b0;
			s_d.fail = 1'b0;
			s_d.monCnt = 5'h00;
		end
		// pll runs when multiplying, when monitoring, or after a failure
		s_d.pllOn = s_d.caught &&
			(!bypassMode || !s_d.monDis || s_d.fail);
		s_d.irq = s_d.stat & s_d.mask;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.strap <= ccm_pkg::STRAP_RST;
			s_q.factor <= ccm_pkg::FACTOR_RST;
			s_q.monDis <= ccm_pkg::MON_DIS_RST;
			s_q.mask <= ccm_pkg::MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign cpuClk = s_q.cpuClk;
	assign cpuRise = s_q.cpuRise;
	assign cpuFall = s_q.cpuFall;
	assign pllOn = s_q.pllOn;
	assign oscBypass = s_q.bypass;
	assign mulFactor = s_q.factor;
	assign clkFail = s_q.fail;
	assign irq = s_q.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_strap_latch: assert property ($rose(s_q.caught) |-> s_q.strap == $past(strapPins))
		else $error("strap not latched");
	a_factor_map: assert property (s_q.caught |-> mulFactor == ccm_pkg::mul_factor(s_q.strap))
		else $error("wrong factor");
	a_presc_phase: assert property (s_q.caught && !s_q.fail && s_q.strap == ccm_pkg::STRAP_PRESC
		&& xtalRise && !swReset |=> $changed(cpuClk) ##1 $stable(cpuClk))
		else $error("prescaler phase wrong");
	a_direct_follow: assert property (s_q.caught && !s_q.fail && s_q.strap == ccm_pkg::STRAP_DIRECT
		&& !swReset |=> cpuClk == $past(xtalIn))
		else $error("direct clock not following input");
	a_edge_pulse: assert property (cpuRise |-> cpuClk && !$past(cpuClk))
		else $error("rise pulse without edge");
	a_pll_off: assert property (s_q.caught && bypassMode && s_q.monDis && !s_q.fail
		&& !wr && !swReset |=> !pllOn)
		else $error("pll not off");
	a_mon_default: assert property ($past(rst) |-> !s_q.monDis)
		else $error("monitor disabled after reset");
	a_mon_bypass: assert property (s_q.caught && !bypassMode |-> s_q.monCnt == 5'h00)
		else $error("monitor running in pll mode");
	a_mon_clear: assert property (monOn && xtalEdge |=> s_q.monCnt == 5'h00)
		else $error("monitor not cleared");
	a_fail_after: assert property ($rose(clkFail) |-> $past(s_q.monCnt) == ccm_pkg::MON_LAST
		&& $past(pllTick))
		else $error("failure not at overflow");
	a_fail_flag: assert property ($rose(clkFail) |-> s_q.stat)
		else $error("failure not flagged");
	a_fail_sticky: assert property (clkFail && !swReset |=> clkFail)
		else $error("failure dropped");
	a_pll_mode: assert property (s_q.caught && !bypassMode && !swReset |=> pllOn)
		else $error("pll off in multiply mode");
	a_switch_clean: assert property (s_q.fail && $changed(cpuClk) |-> $past(pllTick))
		else $error("switch-over glitch");

	a_unlatched_low: assert property (
		!s_q.caught
		|=> !cpuClk)
		else $error("cpu clock running before capture");

	a_recapture: assert property (
		swReset
		|=> !s_q.caught && !clkFail ##1 s_q.caught)
		else $error("software reset did not recapture");

	a_recap_strap: assert property (
		swReset ##1 1'b1
		|=> s_q.strap == $past(strapPins))
		else $error("straps not recaptured");

	a_bypass_code: assert property (
		s_q.caught
		|-> oscBypass == (s_q.strap == ccm_pkg::STRAP_DIRECT))
		else $error("bypass does not match straps");

	a_presc_hold: assert property (
		s_q.caught && !s_q.fail && s_q.strap == ccm_pkg::STRAP_PRESC && !xtalRise
		|=> $stable(cpuClk))
		else $error("prescaler toggled without input rise");

	a_fall_pulse: assert property (
		cpuFall
		|-> !cpuClk && $past(cpuClk))
		else $error("fall pulse without edge");

	a_rise_seen: assert property (
		$rose(cpuClk)
		|-> cpuRise)
		else $error("rising edge not flagged");

	a_fell_seen: assert property (
		$fell(cpuClk)
		|-> cpuFall)
		else $error("falling edge not flagged");

	a_mon_pll: assert property (
		monOn && $past(s_q.caught)
		|-> pllOn)
		else $error("monitor on without pll");

	a_dis_set: assert property (
		wr && addr == ccm_pkg::SYS_CFG_ADDR && wdata[ccm_pkg::MON_DIS_BIT]
		|=> s_q.monDis)
		else $error("monitor disable not taken");

	a_cnt_idle: assert property (
		!monOn
		|=> s_q.monCnt == 5'h00)
		else $error("monitor counting while off");

	a_cnt_step: assert property (
		monOn && !xtalEdge && pllTick && s_q.monCnt != ccm_pkg::MON_LAST && !swReset
		|=> s_q.monCnt == $past(s_q.monCnt) + 5'h01)
		else $error("monitor did not count");

	a_cnt_hold: assert property (
		monOn && !xtalEdge && !pllTick && !swReset
		|=> $stable(s_q.monCnt))
		else $error("monitor counted without tick");

	a_fail_mon: assert property (
		$rose(clkFail)
		|-> $past(monOn))
		else $error("failure without monitor");

	a_fail_pll: assert property (
		clkFail
		|-> pllOn)
		else $error("failure without pll clock");

	a_fail_toggle: assert property (
		s_q.fail && s_q.caught && pllTick
		|=> $changed(cpuClk))
		else $error("pll clock not driving cpu clock");

	a_irq_level: assert property (
		1'b1
		|-> irq == (s_q.stat & s_q.mask))
		else $error("irq not status and mask");

	a_stat_hold: assert property (
		s_q.stat && !(wr && addr == ccm_pkg::STATUS_ADDR && wdata[ccm_pkg::LOSS_EVT_BIT])
		|=> s_q.stat)
		else $error("status dropped without clear");

	a_fail_keep_pll: assert property (
		clkFail && wr && addr == ccm_pkg::SYS_CFG_ADDR && !swReset
		|=> pllOn)
		else $error("pll dropped after failure");

	a_pll_resync: assert property (
		s_q.caught && !s_q.fail && !bypassMode && xtalRise
		|=> cpuClk)
		else $error("pll clock not resynced");

	a_dis_no_fail: assert property (
		s_q.monDis && !s_q.fail
		|=> !clkFail)
		else $error("failure while monitor disabled");

	a_rdata_idle: assert property (
		!$past(rd)
		|-> rdata == '0)
		else $error("read data outside read cycle");

	c_fail_seen: cover property ($rose(clkFail));
	c_irq_seen: cover property ($rose(irq));
	c_presc_toggle: cover property (s_q.strap == ccm_pkg::STRAP_PRESC && cpuRise);
	c_pll_toggle: cover property (!bypassMode && s_q.caught && cpuFall);
	c_stat_clear: cover property ($fell(s_q.stat));
endmodule
`default_nettype wire

// ===== logic/ccm_pkg.sv
`default_nettype none
package ccm_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	// register offsets
	localparam logic [3:0] SYS_CFG_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR  = 4'h1;
	localparam logic [3:0] MASK_ADDR    = 4'h2;
	localparam logic [3:0] MODE_ADDR    = 4'h3;
	// field positions
	localparam int unsigned MON_DIS_BIT   = 4;
	localparam int unsigned LOSS_EVT_BIT  = 0;
	localparam int unsigned MODE_FAIL_BIT = 7;
	localparam int unsigned MODE_PLL_BIT  = 6;
	localparam int unsigned MODE_RDY_BIT  = 5;
	// reset values
	localparam logic       MON_DIS_RST = 1'b0;
	localparam logic       MASK_RST    = 1'b0;
	localparam logic [2:0] STRAP_RST   = 3'h7;
	localparam logic [4:0] FACTOR_RST  = 5'h04;
	// strap codes of the two non-multiplying modes
	localparam logic [2:0] STRAP_DIRECT = 3'h3;
	localparam logic [2:0] STRAP_PRESC  = 3'h1;
	// monitor overflows on the 16th free-running tick
	localparam logic [4:0] MON_LAST     = 5'h0f;
	localparam logic [3:0] PLL_DIV_RST  = 4'h2;

	function automatic logic [4:0] mul_factor(input logic [2:0] strap);
		case (strap)
			3'h7: mul_factor = 5'h04;
			3'h6: mul_factor = 5'h03;
			3'h5: mul_factor = 5'h08;
			3'h4: mul_factor = 5'h05;
			3'h3: mul_factor = 5'h01;
			3'h2: mul_factor = 5'h0a;
			3'h1: mul_factor = 5'h01;
			default: mul_factor = 5'h10;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== testbench/ccm_xtal_model.sv
`default_nettype none
module ccm_xtal_model #(
	parameter int HALF = 4
) (
	input  wire logic clk,
	input  wire logic run,
	output logic      xtalIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// a failed oscillator stays stuck at its last level
	int   cnt = 0;
	logic lvl = 1'b0;
	assign xtalIn = lvl;
	always @(posedge clk) begin
		if (run) begin
			if (cnt == HALF - 1) begin
				cnt <= 0;
				lvl <= ~lvl;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       swReset = 1'b0;
	logic       run = 1'b1;
	logic [2:0] strapPins = 3'h3;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       xtalIn;
	logic [7:0] rdata;
	logic       cpuClk, cpuRise, cpuFall, pllOn, oscBypass, clkFail, irq;
	logic [4:0] mulFactor;
	logic       prevX, prevC;
	int         fails = 0;
	int         check_count = 0;
	int         n;
	logic [4:0] facTab [8] = '{5'h10, 5'h01, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};

	always #12.5 clk = ~clk;

	ccm_xtal_model #(.HALF(4)) u_ccm_xtal_model (.clk(clk), .run(run), .xtalIn(xtalIn));
	ccm_clock_select u_ccm_clock_select (.clk(clk), .rst(rst), .swReset(swReset),
		.xtalIn(xtalIn), .strapPins(strapPins), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .cpuClk(cpuClk), .cpuRise(cpuRise), .cpuFall(cpuFall),
		.pllOn(pllOn), .oscBypass(oscBypass), .mulFactor(mulFactor), .clkFail(clkFail),
		.irq(irq));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask
	task automatic restrap(input logic [2:0] s);
		@(posedge clk);
		strapPins <= s;
		swReset <= 1'b1;
		@(posedge clk);
		swReset <= 1'b0;
		tick(4);
	endtask
	task automatic set_run(input logic v);
		@(posedge clk);
		run <= v;
	endtask
	task automatic wrap_up;
		if (fails == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		tick(3);
		chk("oscBypass", 8'h01, {7'h0, oscBypass});
		chk("mulFactor", 8'h01, {3'h0, mulFactor});
		rd_chk("mode", ccm_pkg::MODE_ADDR, 8'h63);
		rd_chk("config", ccm_pkg::SYS_CFG_ADDR, 8'h00);
		rd_chk("unmapped", 4'h9, 8'h00);
		prevX = xtalIn;
		prevC = cpuClk;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			chk("cpuClk", {7'h0, prevX}, {7'h0, cpuClk});
			chk("cpuRise", {7'h0, cpuClk & ~prevC}, {7'h0, cpuRise});
			chk("cpuFall", {7'h0, ~cpuClk & prevC}, {7'h0, cpuFall});
			prevX = xtalIn;
			prevC = cpuClk;
		end
		wr_reg(ccm_pkg::SYS_CFG_ADDR, 8'h10);
		tick(2);
		chk("pllOn", 8'h00, {7'h0, pllOn});
		set_run(1'b0);
		tick(60);
		chk("clkFail", 8'h00, {7'h0, clkFail});
		set_run(1'b1);
		wr_reg(ccm_pkg::SYS_CFG_ADDR, 8'h00);
		wr_reg(ccm_pkg::MASK_ADDR, 8'h01);
		tick(10);
		chk("pllOn", 8'h01, {7'h0, pllOn});
		set_run(1'b0);
		tick(22);
		chk("clkFail", 8'h00, {7'h0, clkFail});
		tick(16);
		chk("clkFail", 8'h01, {7'h0, clkFail});
		chk("irq", 8'h01, {7'h0, irq});
		rd_chk("status", ccm_pkg::STATUS_ADDR, 8'h01);
		rd_chk("mode", ccm_pkg::MODE_ADDR, 8'he3);
		prevC = cpuClk;
		tick(2);
		chk("pllClk", {7'h0, ~prevC}, {7'h0, cpuClk});
		set_run(1'b1);
		tick(20);
		chk("clkFail", 8'h01, {7'h0, clkFail});
		wr_reg(ccm_pkg::MASK_ADDR, 8'h00);
		tick(2);
		chk("irq", 8'h00, {7'h0, irq});
		wr_reg(ccm_pkg::MASK_ADDR, 8'h01);
		tick(2);
		chk("irq", 8'h01, {7'h0, irq});
		wr_reg(ccm_pkg::STATUS_ADDR, 8'h01);
		tick(2);
		chk("irq", 8'h00, {7'h0, irq});
		restrap(3'h1);
		chk("clkFail", 8'h00, {7'h0, clkFail});
		chk("oscBypass", 8'h00, {7'h0, oscBypass});
		n = 0;
		while (cpuRise !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		n = 0;
		do begin
			tick(1);
			n++;
		end while (cpuFall !== 1'b1 && n < 50);
		chk("highPhase", 8'h08, n[7:0]);
		for (int s = 0; s < 8; s++) begin
			restrap(s[2:0]);
			chk("mulFactor", {3'h0, facTab[s]}, {3'h0, mulFactor});
			chk("oscBypass", {7'h0, s == 3}, {7'h0, oscBypass});
			chk("pllOn", 8'h01, {7'h0, pllOn});
		end
		tick(8);
		n = 0;
		for (int i = 0; i < 16; i++) begin
			tick(1);
			n += int'(cpuRise);
		end
		chk("pllRises", 8'h08, n[7:0]);
		set_run(1'b0);
		tick(60);
		chk("clkFail", 8'h00, {7'h0, clkFail});
		set_run(1'b1);
		wrap_up();
	end

	initial begin
		#500000;
		fails++;
		wrap_up();
	end
endmodule
`default_nettype wire
